/* verilog/flash_cmd_pkg.sv */
// constants and types for the resume, burst-wrap and write-gate command block
//
// Contract
// R1: opcodes 7a and d0 both decode to the same resume function.
// R2: resume acts only when a suspended flag is set and device idle.
// R3: resume ignores the write enable latch state.
// R4: resume opcode is one byte on si, msb first, no address or data.
// R5: resume clears the applicable suspended flag; suspend flag clears when both clear.
// R6: executing resume sets the ready/busy flag to busy.
// R7: suspended operation continues within resume latency after chip select rises.
// R8: resume needs a whole-byte frame; otherwise no resume.
// R9: suspend requests are ignored while busy resuming.
// R10: host waits resume latency or polls flags before suspending again.
// R11: with both suspended, resume restarts program first; erase needs second resume.
// R12: burst-wrap stores wrap bits that later quad reads use.
// R13: wrapped read runs to end of aligned section, then wraps to its start.
// R14: burst-wrap opcode on si, address and wrap data on four lines.
// R15: three address bytes over six clocks, msb first, value ignored.
// R16: eight wrap bits follow; only the middle three are kept.
// R17: wrap length select 00/01/10/11 gives 8/16/32/64 bytes.
// R18: wrap disable bit set means no wrapping until rewritten.
// R19: burst-wrap frame not on a byte boundary is aborted, setting unchanged.
// R20: write-enable command sets the write enable latch.
// R21: program, erase, otp program and status writes need the latch set.
// R22: write enable latch is set when chip select rises after whole byte.
// R23: a suspend sets suspend flag and matching suspended flag, clears busy.
// R24: a program started during erase suspend completes before erase resume.
// R25: wrapped read keeps upper address fixed, lower bits advance modulo length.
package flash_cmd_pkg;

  // ---------------------------------------------------------------
  // opcodes
  // ---------------------------------------------------------------
  localparam logic [7:0] OP_RESUME_LEGACY = 8'h7a;
  localparam logic [7:0] OP_RESUME_NEW    = 8'hd0;
  localparam logic [7:0] OP_BURST_WRAP    = 8'h77;
  localparam logic [7:0] OP_WRITE_ENABLE  = 8'h06;
  localparam logic [7:0] OP_WRITE_DISABLE = 8'h04;
  localparam logic [7:0] OP_PP            = 8'h02;
  localparam logic [7:0] OP_PP_DUAL       = 8'ha2;
  localparam logic [7:0] OP_PP_QUAD       = 8'h32;
  localparam logic [7:0] OP_SEQ_A         = 8'haf;
  localparam logic [7:0] OP_SEQ_B         = 8'had;
  localparam logic [7:0] OP_ERASE_4K      = 8'h20;
  localparam logic [7:0] OP_ERASE_32K     = 8'h52;
  localparam logic [7:0] OP_ERASE_64K     = 8'hd8;
  localparam logic [7:0] OP_ERASE_CHIP_A  = 8'h60;
  localparam logic [7:0] OP_ERASE_CHIP_B  = 8'hc7;
  localparam logic [7:0] OP_OTP_PROGRAM   = 8'h9b;
  localparam logic [7:0] OP_WSR1          = 8'h01;
  localparam logic [7:0] OP_WSR2          = 8'h31;
  localparam logic [7:0] OP_WSR3          = 8'h11;
  localparam logic [7:0] OP_WSR_IND       = 8'h71;
  localparam logic [7:0] OP_QUAD_READ_A   = 8'heb;
  localparam logic [7:0] OP_QUAD_READ_B   = 8'he7;

  // ---------------------------------------------------------------
  // frame layout, in link clocks
  // ---------------------------------------------------------------
  localparam logic [5:0] OPCODE_CLOCKS    = 6'h08;
  localparam logic [5:0] WRAP_ADDR_CLOCKS = 6'h06;
  localparam logic [5:0] WRAP_DATA_CLOCKS = 6'h02;
  localparam logic [5:0] WRAP_END_CLOCK   = 6'h10;

  // wrap byte field positions
  localparam int WRAP_DISABLE_POS = 4;
  localparam int WRAP_LEN_LO_POS  = 5;
  localparam int WRAP_LEN_HI_POS  = 6;

  // power-up wrap setting: disabled
  localparam logic [2:0] WRAP_CONFIG_RESET = 3'h1;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS       = 40;
  localparam int RESUME_LATENCY_NS   = 1000;
  localparam int RESUME_LATENCY_CYC  = (RESUME_LATENCY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0] RESUME_CYC  = 8'(RESUME_LATENCY_CYC);

  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    CMD_NONE   = 2'b00,
    CMD_RESUME = 2'b01,
    CMD_WRAP   = 2'b10,
    CMD_WEN    = 2'b11
  } frame_kind_t;

  typedef struct packed {
    logic suspend_flag;
    logic program_suspended_flag;
    logic erase_suspended_flag;
    logic ready_busy_flag;
    logic write_enable_latch;
  } status_t;

  typedef struct packed {
    logic wrap_length_high_bit;
    logic wrap_length_low_bit;
    logic wrap_disable_bit;
  } wrap_config_field_t;

endpackage

/* verilog/flash_resume_wrap_write_gate.sv */
// resume, burst-wrap and write-enable gating of the serial flash command decoder
`timescale 1ns/1ps

module flash_resume_wrap_write_gate (
  input  wire logic                              clk,
  input  wire logic                              srst,
  input  wire logic                              sck,
  input  wire logic                              cs_n,
  input  wire logic [3:0]                        io_in,
  input  wire logic                              suspend_req,
  input  wire logic                              suspend_is_erase,
  input  wire logic                              op_done,
  input  wire logic                              wel_clear,
  input  wire logic [23:0]                       read_start_addr,
  input  wire logic                              read_start,
  input  wire logic                              read_step,
  output logic      [23:0]                       read_addr,
  output flash_cmd_pkg::status_t                 status,
  output flash_cmd_pkg::wrap_config_field_t      wrap_config_field,
  output logic                                   resume_go,
  output logic                                   resume_program,
  output logic                                   exec_allowed,
  output logic                                   exec_pulse,
  output logic      [7:0]                        exec_opcode
);

  // ---------------------------------------------------------------
  // link domain: shift in the frame on sck
  // ---------------------------------------------------------------
  logic [7:0]  lk_shift;
  logic [5:0]  lk_count;
  logic [7:0]  lk_opcode;
  logic [7:0]  lk_wrap;
  logic [5:0]  next_lk_count;
  logic        lk_armed;
  logic [5:0]  lk_index;
  logic [5:0]  lk_len;

  // armed while cs_n is high; the first sck of a frame restarts the count
  always_ff @(posedge sck or posedge cs_n) begin
    if (cs_n) begin
      lk_armed <= 1'b1;
    end else begin
      lk_armed <= 1'b0;
    end
  end

  assign lk_index      = lk_armed ? 6'h00 : lk_count;
  assign next_lk_count = lk_index + 6'h01;

  // not cleared by cs_n, so the final count survives the frame end
  always_ff @(posedge sck) begin
    if (!cs_n && lk_index != 6'h3f) begin
      lk_count <= next_lk_count;
    end
  end

  // frame length taken on the cs_n rise; a frame with no clocks reads as zero
  always_ff @(posedge cs_n) begin
    lk_len <= lk_index;
  end

  always_ff @(posedge sck) begin
    if (!cs_n) begin
      if (lk_index < flash_cmd_pkg::OPCODE_CLOCKS) begin
        lk_shift <= {lk_shift[6:0], io_in[0]}; // R4
        if (lk_index == flash_cmd_pkg::OPCODE_CLOCKS - 6'h01) begin
          lk_opcode <= {lk_shift[6:0], io_in[0]};
        end
      end else if (lk_index >= flash_cmd_pkg::OPCODE_CLOCKS + flash_cmd_pkg::WRAP_ADDR_CLOCKS) begin
        lk_wrap <= {lk_wrap[3:0], io_in}; // R14 R15 R16
      end
    end
  end

  // frame summary is stable after cs_n rises; read by the core at frame_end, once the rise has passed the synchronizer
  // ---------------------------------------------------------------
  // crossing: cs_n level and frame end
  // ---------------------------------------------------------------
  logic cs_meta;
  logic cs_sync;
  logic cs_prev;
  logic frame_end;

  always_ff @(posedge clk) begin
    if (srst) begin
      cs_meta <= 1'b1;
      cs_sync <= 1'b1;
      cs_prev <= 1'b1;
    end else begin
      cs_meta <= cs_n;
      cs_sync <= cs_meta;
      cs_prev <= cs_sync;
    end
  end

  assign frame_end = cs_sync & ~cs_prev;

  // link registers hold still while cs_n is high, so sampling here is safe
  function automatic flash_cmd_pkg::frame_kind_t decode_frame(input logic [7:0] op,
                                                              input logic [5:0] cnt);
    decode_frame = flash_cmd_pkg::CMD_NONE;
    if (cnt == flash_cmd_pkg::OPCODE_CLOCKS &&
        (op == flash_cmd_pkg::OP_RESUME_LEGACY || op == flash_cmd_pkg::OP_RESUME_NEW)) begin
      decode_frame = flash_cmd_pkg::CMD_RESUME; // R1 R8
    end else if (cnt == flash_cmd_pkg::WRAP_END_CLOCK && op == flash_cmd_pkg::OP_BURST_WRAP) begin
      decode_frame = flash_cmd_pkg::CMD_WRAP; // R19
    end else if (cnt == flash_cmd_pkg::OPCODE_CLOCKS && op == flash_cmd_pkg::OP_WRITE_ENABLE) begin
      decode_frame = flash_cmd_pkg::CMD_WEN; // R22
    end
  endfunction

  function automatic logic needs_wel(input logic [7:0] op);
    case (op)
      flash_cmd_pkg::OP_PP, flash_cmd_pkg::OP_PP_DUAL, flash_cmd_pkg::OP_PP_QUAD,
      flash_cmd_pkg::OP_SEQ_A, flash_cmd_pkg::OP_SEQ_B,
      flash_cmd_pkg::OP_ERASE_4K, flash_cmd_pkg::OP_ERASE_32K, flash_cmd_pkg::OP_ERASE_64K,
      flash_cmd_pkg::OP_ERASE_CHIP_A, flash_cmd_pkg::OP_ERASE_CHIP_B,
      flash_cmd_pkg::OP_OTP_PROGRAM,
      flash_cmd_pkg::OP_WSR1, flash_cmd_pkg::OP_WSR2, flash_cmd_pkg::OP_WSR3,
      flash_cmd_pkg::OP_WSR_IND: needs_wel = 1'b1;
      default: needs_wel = 1'b0;
    endcase
  endfunction

  flash_cmd_pkg::frame_kind_t kind;
  logic                       whole_bytes;

  assign kind        = frame_end ? decode_frame(lk_opcode, lk_len) : flash_cmd_pkg::CMD_NONE;
  assign whole_bytes = (lk_len[2:0] == 3'h0) && (lk_len != 6'h00) && (lk_len != 6'h3f);

  // ---------------------------------------------------------------
  // resume latency timer
  // ---------------------------------------------------------------
  logic [7:0] resume_timer;
  logic       resuming;
  logic       resume_ok;

  assign resuming  = resume_timer != 8'h00;
  assign resume_ok = (kind == flash_cmd_pkg::CMD_RESUME) &&
                     (status.erase_suspended_flag | status.program_suspended_flag) &&
                     !status.ready_busy_flag; // R2 R3

  always_ff @(posedge clk) begin
    if (srst) begin
      resume_timer <= 8'h00;
    end else if (resume_ok) begin
      resume_timer <= flash_cmd_pkg::RESUME_CYC; // R7
    end else if (resuming) begin
      resume_timer <= resume_timer - 8'h01;
    end
  end

  // ---------------------------------------------------------------
  // status flags
  // ---------------------------------------------------------------
  logic take_suspend;
  logic exec_go;
  logic next_ps;
  logic next_es;

  assign take_suspend = suspend_req && status.ready_busy_flag && !resuming; // R9

  always_comb begin
    next_ps = status.program_suspended_flag;
    next_es = status.erase_suspended_flag;
    if (resume_ok) begin
      if (status.program_suspended_flag) begin
        next_ps = 1'b0; // R5 R11
      end else begin
        next_es = 1'b0; // R5
      end
    end
    if (take_suspend) begin
      if (suspend_is_erase) begin
        next_es = 1'b1; // R23
      end else begin
        next_ps = 1'b1; // R23
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      status.program_suspended_flag <= 1'b0;
      status.erase_suspended_flag   <= 1'b0;
      status.suspend_flag           <= 1'b0;
    end else begin
      status.program_suspended_flag <= next_ps;
      status.erase_suspended_flag   <= next_es;
      status.suspend_flag           <= next_ps | next_es; // R5 R23
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      status.ready_busy_flag <= 1'b0;
    end else if (resume_ok) begin
      status.ready_busy_flag <= 1'b1; // R6
    end else if (exec_go) begin
      // a gated command that executes starts the program, erase, otp program or status write operation
      status.ready_busy_flag <= 1'b1;
    end else if (take_suspend) begin
      status.ready_busy_flag <= 1'b0; // R23
    end else if (op_done && !resuming) begin
      status.ready_busy_flag <= 1'b0;
    end
  end

  assign resume_go      = resume_ok;
  assign resume_program = status.program_suspended_flag; // R11

  // ---------------------------------------------------------------
  // write enable latch and write gating
  // ---------------------------------------------------------------
  logic gated_frame;

  assign gated_frame = frame_end && whole_bytes && needs_wel(lk_opcode);
  assign exec_go     = gated_frame && status.write_enable_latch; // R21

  always_ff @(posedge clk) begin
    if (srst) begin
      status.write_enable_latch <= 1'b0;
    end else if (kind == flash_cmd_pkg::CMD_WEN) begin
      status.write_enable_latch <= 1'b1; // R20 R22
    end else if (wel_clear ||
                 (frame_end && lk_len == flash_cmd_pkg::OPCODE_CLOCKS &&
                  lk_opcode == flash_cmd_pkg::OP_WRITE_DISABLE)) begin
      status.write_enable_latch <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      exec_pulse   <= 1'b0;
      exec_opcode  <= 8'h00;
    end else begin
      exec_pulse   <= exec_go; // R21
      exec_opcode  <= gated_frame ? lk_opcode : exec_opcode;
    end
  end

  assign exec_allowed = status.write_enable_latch; // R21

  // ---------------------------------------------------------------
  // burst wrap configuration
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      wrap_config_field <= flash_cmd_pkg::WRAP_CONFIG_RESET;
    end else if (kind == flash_cmd_pkg::CMD_WRAP) begin
      wrap_config_field <= lk_wrap[flash_cmd_pkg::WRAP_LEN_HI_POS:flash_cmd_pkg::WRAP_DISABLE_POS]; // R12 R16
    end
  end

  // ---------------------------------------------------------------
  // wrapped read address counter
  // ---------------------------------------------------------------
  logic [23:0] wrap_mask;
  logic [23:0] next_read_addr;

  always_comb begin
    case ({wrap_config_field.wrap_length_high_bit, wrap_config_field.wrap_length_low_bit}) // R17
      2'b00:   wrap_mask = 24'h000007;
      2'b01:   wrap_mask = 24'h00000f;
      2'b10:   wrap_mask = 24'h00001f;
      2'b11:   wrap_mask = 24'h00003f;
      default: wrap_mask = 24'h000007;
    endcase
    if (wrap_config_field.wrap_disable_bit) begin
      next_read_addr = read_addr + 24'h000001; // R18
    end else begin
      next_read_addr = (read_addr & ~wrap_mask) | ((read_addr + 24'h000001) & wrap_mask); // R13 R25
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      read_addr <= 24'h000000;
    end else if (read_start) begin
      read_addr <= read_start_addr;
    end else if (read_step) begin
      read_addr <= next_read_addr;
    end
  end

endmodule // flash_resume_wrap_write_gate

/* testbench/flash_gate_checker_assertions.sv */
// concurrent checks on the resume, wrap and write-gate block
`timescale 1ns/1ps
module flash_gate_checker (
  input wire logic                              clk,
  input wire logic                              srst,
  input wire logic                              cs_n,
  input wire logic                              suspend_req,
  input wire logic                              suspend_is_erase,
  input wire logic                              read_start,
  input wire logic                              read_step,
  input wire logic [23:0]                       read_addr,
  input wire flash_cmd_pkg::status_t            status,
  input wire flash_cmd_pkg::wrap_config_field_t wrap_config_field,
  input wire logic                              resume_go,
  input wire logic                              exec_allowed,
  input wire logic                              exec_pulse
);
  logic [4:0]  tmr;
  logic [1:0]  sus;
  logic [23:0] msk;
  assign sus = {status.program_suspended_flag, status.erase_suspended_flag};
  assign msk = (24'h8 << wrap_config_field[2:1]) - 24'h1;
  // latency window, kept a little longer than the design's
  always_ff @(posedge clk) begin
    if (srst) tmr <= 5'h0;
    else if (resume_go) tmr <= 5'h1a;
    else if (tmr != 5'h0) tmr <= tmr - 5'h1;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  res_allowed_a: assert property (resume_go |-> sus != 2'h0 && !status.ready_busy_flag)
    else $error("resume taken when not allowed");
  res_busy_a: assert property (resume_go |=> status.ready_busy_flag)
    else $error("resume left device idle");
  res_order_a: assert property (resume_go && sus[1] && !suspend_req |=> sus == {1'b0, $past(sus[0])})
    else $error("resume did not clear program first");
  res_last_a: assert property (resume_go && sus == 2'h1 |=> sus == 2'h0 && !status.suspend_flag)
    else $error("suspend flag kept after last resume");
  suspend_flag_ignore_a: assert property (suspend_req && tmr > 5'h2 |=> $stable(sus))
    else $error("suspend taken while resuming");
  suspend_flag_flags_a: assert property (suspend_req && status.ready_busy_flag && tmr == 5'h0 |=>
    !status.ready_busy_flag && status.suspend_flag && sus[!$past(suspend_is_erase)])
    else $error("suspend flags wrong");
  gate_exec_a: assert property (exec_pulse |-> $past(exec_allowed) && !$past(exec_pulse))
    else $error("gated command ran without latch");
  wrap_step_a: assert property (read_step && !read_start && !wrap_config_field[0] |=>
    (read_addr & ~msk) == ($past(read_addr) & ~msk) && (read_addr & msk) == (($past(read_addr) + 24'h1) & msk))
    else $error("wrapped step wrong");
  wrap_off_a: assert property (read_step && !read_start && wrap_config_field[0] |=> read_addr == $past(read_addr) + 24'h1)
    else $error("linear step wrong");
  wrap_hold_a: assert property (!$stable(wrap_config_field) |-> cs_n)
    else $error("wrap setting changed inside a frame");
endmodule // flash_gate_checker

bind flash_resume_wrap_write_gate flash_gate_checker flash_gate_checker_i (.clk, .srst, .cs_n, .suspend_req,
  .suspend_is_erase, .read_start, .read_step, .read_addr, .status, .wrap_config_field, .resume_go,
  .exec_allowed, .exec_pulse);

/* testbench/spi_host_model.sv */
// host controller model driving the serial link in mode 0
`timescale 1ns/1ps
module spi_host_model (
  output logic       sck,
  output logic       cs_n,
  output logic [3:0] io_in
);
  initial begin
    sck = 1'b0;
    cs_n = 1'b0;
    io_in = 4'h5;
    // a clean rising edge at power-up arms the link side
    #1 cs_n = 1'b1;
  end
  // ops opcode bits on line 0, then nqs nibbles on all four lines, msb first
  task automatic frame(input logic [7:0] op, input int ops, input logic [31:0] nib, input int nqs);
    #7 cs_n = 1'b0;
    for (int i = 0; i < ops + nqs; i++) begin
      if (i < ops) io_in = {~io_in[3:1], op[7 - i]};
      else io_in = nib[31 - 4 * (i - ops) -: 4];
      #24 sck = 1'b1;
      #24 sck = 1'b0;
    end
    #24 cs_n = 1'b1;
    // released lines must not keep the last value
    io_in = ~io_in;
  endtask
endmodule // spi_host_model

/* testbench/testbench.sv */
// self-checking bench for the resume, wrap and write-gate block
`timescale 1ns/1ps
module testbench;
  logic                              clk, srst, suspend_req, suspend_is_erase, op_done, wel_clear;
  logic                              read_start, read_step, sck, cs_n;
  logic                              resume_go, resume_program, exec_allowed, exec_pulse, go_seen, ex_seen;
  logic [3:0]                        io_in;
  logic [7:0]                        exec_opcode;
  logic [23:0]                       read_start_addr, read_addr;
  flash_cmd_pkg::status_t            status;
  flash_cmd_pkg::wrap_config_field_t wrap_config_field;
  int                                num_errors = 0;
  int                                num_checks = 0;
  logic [7:0] gated [15] = '{8'h02, 8'ha2, 8'h32, 8'haf, 8'had, 8'h20, 8'h52, 8'hd8, 8'h60, 8'hc7, 8'h9b,
                            8'h01, 8'h31, 8'h11, 8'h71};

  spi_host_model spi_host_model_i (.sck, .cs_n, .io_in);
  flash_resume_wrap_write_gate flash_resume_wrap_write_gate_i (.clk, .srst, .sck, .cs_n, .io_in, .suspend_req,
    .suspend_is_erase, .op_done, .wel_clear, .read_start_addr, .read_start, .read_step, .read_addr, .status,
    .wrap_config_field, .resume_go, .resume_program, .exec_allowed, .exec_pulse, .exec_opcode);

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED %0t %s got %0h exp %0h", $time, what, got, exp);
    end
  endtask
  task automatic pulse(input int k);
    @(posedge clk);
    {read_step, read_start, wel_clear, op_done, suspend_req} <= 5'(1 << k);
    @(posedge clk);
    {read_step, read_start, wel_clear, op_done, suspend_req} <= 5'h0;
    @(negedge clk);
  endtask
  task automatic send(input logic [7:0] op, input int ops, input logic [31:0] nib, input int nqs);
    spi_host_model_i.frame(op, ops, nib, nqs);
    go_seen = 1'b0;
    ex_seen = 1'b0;
    repeat (10) begin
      @(negedge clk);
      if (resume_go === 1'b1) go_seen = 1'b1;
      if (exec_pulse === 1'b1) ex_seen = 1'b1;
    end
  endtask
  task automatic suspend(input logic erase);
    @(posedge clk);
    suspend_is_erase <= erase;
    pulse(0);
  endtask
  task automatic read_from(input logic [23:0] a);
    @(posedge clk);
    read_start_addr <= a;
    pulse(3);
  endtask
  task automatic give_verdict();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_gate();
    send(8'h02, 8, 32'h0, 0);
    chk(ex_seen, 1'b0, "exec without latch");
    send(8'h06, 5, 32'h0, 0);
    chk(status[0], 1'b0, "short enable frame");
    foreach (gated[i]) begin
      send(8'h06, 8, 32'h0, 0);
      chk(exec_allowed, 1'b1, "latch set");
      send(gated[i], 8, 32'h0, 0);
      chk({ex_seen, exec_opcode}, {1'b1, gated[i]}, "gated exec");
      pulse(1);
      pulse(2);
    end
    send(8'h06, 8, 32'h0, 0);
    send(8'h04, 8, 32'h0, 0);
    send(8'h20, 8, 32'h0, 0);
    chk({status[0], ex_seen}, 2'h0, "exec after disable");
  endtask
  task automatic t_resume();
    send(8'h7a, 8, 32'h0, 0);
    chk(go_seen, 1'b0, "resume, none suspended");
    send(8'h06, 8, 32'h0, 0);
    send(8'hd8, 8, 32'h0, 0);
    suspend(1'b1);
    chk(status[4:1], 4'ha, "erase suspended");
    send(8'h06, 8, 32'h0, 0);
    send(8'h02, 8, 32'h0, 0);
    suspend(1'b0);
    chk({status[4:1], resume_program}, 5'h1d, "both suspended");
    pulse(2);
    send(8'h7a, 5, 32'h0, 0);
    chk({go_seen, status[4:1]}, 5'h0e, "short resume frame");
    send(8'h7a, 8, 32'h0, 0);
    chk({go_seen, status[4:0]}, 6'h36, "program resumed");
    suspend(1'b0);
    chk(status[4:1], 4'hb, "suspend while resuming");
    send(8'hd0, 8, 32'h0, 0);
    chk(go_seen, 1'b0, "resume while busy");
    repeat (30) @(negedge clk);
    pulse(1);
    chk(status[1], 1'b0, "program done");
    send(8'hd0, 8, 32'h0, 0);
    chk({go_seen, status[4:1]}, 5'h11, "erase resumed");
    repeat (30) @(negedge clk);
    pulse(1);
  endtask
  task automatic t_wrap();
    logic [23:0] m;
    for (int l = 0; l < 4; l++) begin
      send(8'h77, 8, {24'hc3a5f0, 1'b1, 2'(l), 5'h0f}, 8);
      chk(wrap_config_field, {2'(l), 1'b0}, "wrap length");
      m = (24'h8 << l) - 24'h1;
      read_from(24'h1006);
      for (int i = 1; i <= (8 << l); i++) begin
        pulse(4);
        chk(read_addr, (24'h1006 & ~m) | ((24'h1006 + 24'(i)) & m), "wrapped address");
      end
    end
    send(8'h77, 8, 32'h00000070, 7);
    chk(wrap_config_field, 3'h6, "aborted wrap frame");
    send(8'h77, 8, 32'h00000070, 8);
    chk(wrap_config_field, 3'h7, "wrap disabled");
    read_from(24'h103e);
    repeat (4) pulse(4);
    chk(read_addr, 24'h1042, "linear read");
  endtask

  initial begin
    {srst, suspend_req, suspend_is_erase, op_done, wel_clear, read_start, read_step} = 7'h40;
    read_start_addr = 24'h0;
    repeat (4) @(posedge clk);
    srst <= 1'b0;
    repeat (4) @(negedge clk);
    chk({status, wrap_config_field, read_addr}, {5'h0, 3'h1, 24'h0}, "reset values");
    t_gate();
    t_resume();
    t_wrap();
    give_verdict();
  end

  initial begin
    #400000;
    num_errors++;
    give_verdict();
  end
endmodule // testbench
